// ---- hdl/wake_event_status_enable.sv ----
// event group 1 status flags, first enable byte and the power management interrupt
// assumes an APB master on mclk; event sources arrive from other clock domains or pins

`timescale 1ns/1ns

module wake_event_status_enable #(
   parameter int ADDR_W   = 12,  // apb address width
   parameter int GPIO_PINS = 8   // pins of gpio event port 1
) (
   input  wire logic                     mclk,
   input  wire logic                     arst_n,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [ADDR_W-1:0]        paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire wake_event_pkg::wake_src_s wake_src,
   input  wire logic                     kbc_active,
   input  wire logic [GPIO_PINS-1:0]     gpio_event_port,
   input  wire logic [3:0]               flag_enable,
   output logic                          power_mgmt_interrupt,
   output logic                          pm_alarm_flag_clear
);

   // width of the vector that crosses in through the synchronisers
   localparam int SYNC_W = wake_event_pkg::STS_WIDTH + 1 + GPIO_PINS;

   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   logic [SYNC_W-1:0] async_in;   // raw asynchronous inputs
   logic [SYNC_W-1:0] sync_meta;  // first stage, read only by the second
   logic [SYNC_W-1:0] sync_in;    // second stage, safe to use

   assign async_in = {gpio_event_port, kbc_active, wake_src};

   // one two-stage synchroniser per bit
   // a bit that moves near an edge may land a cycle late; that only delays
   // a flag, and a level that stays up is never lost
   genvar gi;
   generate
      for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
         always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
               sync_meta[gi] <= 1'b0;
               sync_in[gi]   <= 1'b0;
            end else begin
               sync_meta[gi] <= async_in[gi];
               sync_in[gi]   <= sync_meta[gi];
            end
         end
      end
   endgenerate

   // synchronised views
   // slices follow async_in: the struct sits in the low four bits
   logic [3:0]           src_s;     // mouse, keyboard, pin twelve, alarm
   logic                 active_s;  // controller module active
   logic [GPIO_PINS-1:0] gpio_s;    // gpio event port 1 pins

   assign src_s    = sync_in[3:0];
   assign active_s = sync_in[4];
   assign gpio_s   = sync_in[SYNC_W-1:5];

   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   logic sel_status;   // status byte addressed
   logic sel_enable;   // enable byte addressed
   logic sel_wakecfg;  // wake configuration addressed
   logic sel_any;      // any mapped register
   logic access;       // access phase of a transfer
   logic wr_status;    // write to the status byte takes effect
   logic wr_enable;    // write to the enable byte takes effect
   logic wr_wakecfg;   // write to the wake configuration takes effect
   logic rd_setup;     // setup phase of a read

   // full address compare, so a stray offset can never alias a register
   assign sel_status  = (paddr == ADDR_W'(wake_event_pkg::ADDR_STATUS));
   assign sel_enable  = (paddr == ADDR_W'(wake_event_pkg::ADDR_ENABLE));
   assign sel_wakecfg = (paddr == ADDR_W'(wake_event_pkg::ADDR_WAKECFG));
   assign sel_any     = sel_status | sel_enable | sel_wakecfg;
   assign access      = psel & penable;
   assign wr_status   = access & pwrite & sel_status;
   assign wr_enable   = access & pwrite & sel_enable;
   assign wr_wakecfg  = access & pwrite & sel_wakecfg;
   assign rd_setup    = psel & ~penable & ~pwrite;

   // the slave never stretches a transfer, so masters see one access cycle
   // zero wait states: read data is already captured in the setup cycle
   assign pready  = 1'b1;
   // unmapped addresses answer with an error and change nothing
   assign pslverr = access & ~sel_any;

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [3:0]           status;        // sticky event flags
   logic [GPIO_PINS-1:0] enable;        // event_group1_enable_vector bits 7..0
   logic [1:0]           wakecfg;       // mouse and keyboard wake enables
   logic [3:0]           set_vec;       // qualified events this cycle
   logic [3:0]           clr_vec;       // bits written with one
   logic [3:0]           keep_vec;      // set flags not being cleared
   logic [3:0]           next_status;   // status after this edge
   logic                 pending;       // an enabled event is set
   logic [31:0]          rdata_mux;     // read data before capture
   logic [7:0]           wdata_byte;    // low byte of write data

   assign wdata_byte = pwdata[7:0];

   // sources are levels: one still high after a clear sets its flag again,
   // so software must quiet the source before the clear is final
   // event qualification; a level held high keeps the flag set
   assign set_vec[wake_event_pkg::STS_MOUSE] = src_s[wake_event_pkg::STS_MOUSE]
          & wakecfg[wake_event_pkg::CFG_MOUSE_WAKE] & active_s;
   assign set_vec[wake_event_pkg::STS_KEYBOARD] = src_s[wake_event_pkg::STS_KEYBOARD]
          & wakecfg[wake_event_pkg::CFG_KBD_WAKE] & active_s;
   assign set_vec[wake_event_pkg::STS_PIN_TWELVE] =
          src_s[wake_event_pkg::STS_PIN_TWELVE] & active_s;
   assign set_vec[wake_event_pkg::STS_ALARM] = src_s[wake_event_pkg::STS_ALARM];

   // write one to clear, zero ignored
   assign clr_vec = wr_status ? pwdata[3:0] : 4'h0;

   // set wins over a clear in the same cycle so no event is lost
   assign keep_vec    = status & ~clr_vec;
   assign next_status = keep_vec | set_vec;

   // limitation: the pins keep no status of their own here; a pin that drops
   // before software looks leaves no trace in this block
   // each enable bit gates its own pin; the four flags use the other bytes
   assign pending = (|(gpio_s & enable)) | (|(status & flag_enable));

   // reading has no side effect, so capturing it in setup is harmless
   // read selection; unimplemented bits read as zero
   assign rdata_mux = sel_status  ? {28'h0, status}  :
                      sel_enable  ? {24'h0, enable}  :
                      sel_wakecfg ? {30'h0, wakecfg} : 32'h0;

   // status flags
   // all four flags in one register; the next value is formed above
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         status <= wake_event_pkg::STATUS_RESET;
      end else begin
         status <= next_status;
      end
   end

   // enable byte, plain read/write
   // only the low byte of the bus word reaches the register
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         enable <= GPIO_PINS'(wake_event_pkg::ENABLE_RESET);
      end else if (wr_enable) begin
         enable <= wdata_byte[GPIO_PINS-1:0];
      end
   end

   // wake configuration of the controller irqs
   // stands in for the wake enables held in each controller's own configuration
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wakecfg <= wake_event_pkg::WAKECFG_RESET;
      end else if (wr_wakecfg) begin
         wakecfg <= pwdata[1:0];
      end
   end

   // read data capture, held after the transfer
   // loading in setup keeps prdata a flop output and still needs no wait state
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         prdata <= 32'h0;
      end else if (rd_setup) begin
         prdata <= rdata_mux;
      end
   end

   // interrupt and the block-status clear strobe, one cycle after cause
   // registered so the pin never glitches, at the cost of one cycle of latency
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         power_mgmt_interrupt <= 1'b0;
         pm_alarm_flag_clear  <= 1'b0;
      end else begin
         power_mgmt_interrupt <= pending;
         pm_alarm_flag_clear  <= clr_vec[wake_event_pkg::STS_ALARM];
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);
   // every check sleeps while reset is low, except the two reset checks

   // qualified mouse irq sets its flag
   chk_mouse_flag_set: assert property (
      (src_s[3] && wakecfg[0] && active_s) |=> status[3]) else $error("mouse flag not set");

   // keyboard irq without wake enable or activity leaves a clear flag clear
   chk_kbd_flag_gate: assert property (
      (!status[2] && (!wakecfg[1] || !active_s)) |=> !status[2])
      else $error("keyboard flag gating wrong");

   // pin twelve with controller active sets its flag
   chk_pin_flag_set: assert property (
      (src_s[1] && active_s) |=> status[1]) else $error("pin flag not set");

   // alarm sets its flag
   chk_alarm_flag_set: assert property (
      src_s[0] |=> status[0]) else $error("alarm flag not set");

   // alarm clear drops the flag and pulses the block-status clear
   chk_alarm_clear: assert property (
      (wr_status && pwdata[0] && !src_s[0]) |=> (!status[0] && pm_alarm_flag_clear)
      ##1 (!pm_alarm_flag_clear || $past(wr_status && pwdata[0])))
      else $error("alarm clear wrong");

   // written one clears the mouse flag when no event is present
   chk_mouse_w1c: assert property (
      (wr_status && pwdata[3] && !set_vec[3]) |=> !status[3])
      else $error("mouse flag not cleared");

   // set flags stay set unless cleared
   chk_flag_sticky: assert property (
      ##1 ((status & $past(keep_vec)) == $past(keep_vec)))
      else $error("flag lost without clear");

   // enable byte takes the written data on the next edge
   chk_enable_write: assert property (
      wr_enable |=> (enable == $past(wdata_byte))) else $error("enable write lost");

   // enabled pin 7 event raises the interrupt
   chk_pin7_raise: assert property (
      (enable[7] && gpio_s[7]) |=> power_mgmt_interrupt) else $error("pin 7 irq missing");

   // nothing enabled and nothing set keeps the interrupt low
   chk_irq_quiet: assert property (
      (!pending) [*2] |-> ##1 !power_mgmt_interrupt) else $error("spurious interrupt");

   // the interrupt follows the pending term by one cycle
   chk_irq_follow: assert property (
      ##1 (power_mgmt_interrupt == $past(pending))) else $error("interrupt mismatch");

   // qualified keyboard irq sets its flag
   chk_kbd_flag_set: assert property (
      (src_s[2] && wakecfg[1] && active_s) |=> status[2]) else $error("keyboard flag not set");

   // mouse irq without wake enable or activity leaves a clear flag clear
   chk_mouse_flag_gate: assert property (
      (!status[3] && (!wakecfg[0] || !active_s)) |=> !status[3])
      else $error("mouse flag gating wrong");

   // pin twelve with the controller idle leaves a clear flag clear
   chk_pin_flag_gate: assert property (
      (!status[1] && !active_s) |=> !status[1]) else $error("pin flag gating wrong");

   // a clear pulse only ever follows a written one on the alarm bit
   chk_alarm_pulse_cause: assert property (
      pm_alarm_flag_clear |-> $past(wr_status && pwdata[0]))
      else $error("clear pulse without write");

   // a written zero on the alarm bit sends no clear pulse
   chk_alarm_zero_write: assert property (
      (wr_status && !pwdata[0]) |=> !pm_alarm_flag_clear) else $error("clear pulse on zero");

   // the clear pulse lasts one cycle, as access cycles never run back to back
   chk_alarm_pulse_width: assert property (
      pm_alarm_flag_clear |=> !pm_alarm_flag_clear) else $error("clear pulse too long");

   // written one clears the keyboard flag when no event is present
   chk_kbd_w1c: assert property (
      (wr_status && pwdata[2] && !set_vec[2]) |=> !status[2])
      else $error("keyboard flag not cleared");

   // written one clears the pin flag when no event is present
   chk_pin_w1c: assert property (
      (wr_status && pwdata[1] && !set_vec[1]) |=> !status[1])
      else $error("pin flag not cleared");

   // flags come out of reset clear
   chk_status_reset: assert property (
      disable iff (1'b0) !arst_n |=> (status == '0)) else $error("status not reset");

   // enable byte holds unless its own write takes effect
   chk_enable_hold: assert property (
      !wr_enable |=> $stable(enable)) else $error("enable changed without write");

   // a write to an unmapped offset leaves both registers alone
   chk_unmapped_write: assert property (
      (access && pwrite && !sel_any) |=> ($stable(enable) && $stable(wakecfg)))
      else $error("unmapped write landed");

   // a read of the enable byte returns it in the access cycle
   chk_enable_read: assert property (
      (rd_setup && sel_enable) |=> (prdata == 32'($past(enable))))
      else $error("enable read data wrong");

   // pin 7 with its enable clear and nothing else pending stays quiet
   chk_pin7_gate: assert property (
      (!enable[7] && gpio_s[7] && !(|(gpio_s[GPIO_PINS-2:0] & enable[GPIO_PINS-2:0]))
      && !(|(status & flag_enable))) |=> !power_mgmt_interrupt) else $error("pin 7 not gated");

   // enable bits and the interrupt come out of reset low
   chk_enable_reset: assert property (
      disable iff (1'b0) !arst_n |=> ((enable == '0) && !power_mgmt_interrupt))
      else $error("enable not reset");

   // any enabled pin from 6 down to 0 raises the interrupt
   chk_low_pins_raise: assert property (
      (|(enable[GPIO_PINS-2:0] & gpio_s[GPIO_PINS-2:0])) |=> power_mgmt_interrupt)
      else $error("low pin irq missing");

   // an enabled status flag raises the interrupt
   chk_flag_irq: assert property (
      (|(status & flag_enable)) |=> power_mgmt_interrupt) else $error("flag irq missing");

   // main scenarios
   cov_mouse_wake:  cover property (set_vec[3] ##1 status[3]);
   cov_alarm_clear: cover property (status[0] && wr_status && pwdata[0]);
   cov_irq_rise:    cover property ($rose(power_mgmt_interrupt));
   cov_bad_addr:    cover property (pslverr);
   cov_set_beats_clear: cover property (wr_status && (|(pwdata[3:0] & set_vec)));

endmodule

// ---- pkg/wake_event_pkg.sv ----
// package for the wake event status and enable block
// assumes a 32-bit APB master on the same clock as the block

package wake_event_pkg;

   // register byte offsets on the APB bus
   localparam logic [11:0] ADDR_STATUS  = 12'h000;  // event status byte, write one to clear
   localparam logic [11:0] ADDR_ENABLE  = 12'h004;  // gpio event port 1 enable byte
   localparam logic [11:0] ADDR_WAKECFG = 12'h008;  // wake enables of the controller irqs

   // status byte field positions
   localparam int STS_ALARM      = 0;  // alarm_event_flag
   localparam int STS_PIN_TWELVE = 1;  // kbc_pin_event_flag
   localparam int STS_KEYBOARD   = 2;  // keyboard_wake_irq_flag
   localparam int STS_MOUSE      = 3;  // mouse_wake_irq_flag
   localparam int STS_WIDTH      = 4;  // implemented status bits

   // wake configuration field positions
   localparam int CFG_MOUSE_WAKE = 0;  // mouse irq wake enable
   localparam int CFG_KBD_WAKE   = 1;  // keyboard irq wake enable
   localparam int CFG_WIDTH      = 2;

   // reset values
   localparam logic [3:0] STATUS_RESET  = 4'h0;
   localparam logic [7:0] ENABLE_RESET  = 8'h00;
   localparam logic [1:0] WAKECFG_RESET = 2'h0;

   // event sources from the keyboard/mouse controller and the clock alarm
   typedef struct packed {
      logic mouse_irq;   // mouse section irq
      logic kbd_irq;     // keyboard section irq
      logic pin_twelve;  // controller_port_pin_twelve driven high
      logic alarm;       // enabled clock alarm occurred
   } wake_src_s;

endpackage

// ---- testbench/wake_event_status_enable_tb.sv ----
// self-checking bench for the wake event status and enable block
// assumes zero wait APB on mclk; event inputs are driven as slow levels

`timescale 1ns/1ns

module wake_event_status_enable_tb;
   logic                      mclk;                 // 125 MHz bench clock
   logic                      arst_n;               // async reset, active low
   logic                      psel;                 // apb select
   logic                      penable;              // apb access phase
   logic                      pwrite;               // apb direction
   logic [11:0]               paddr;                // apb byte address
   logic [31:0]               pwdata;               // apb write data
   logic [31:0]               prdata;               // apb read data
   logic                      pready;               // apb ready
   logic                      pslverr;              // apb error
   wake_event_pkg::wake_src_s wake_src;             // event sources
   logic                      kbc_active;           // controller active
   logic [7:0]                gpio_event_port;      // port 1 pin events
   logic [3:0]                flag_enable;          // status flag enables
   logic                      power_mgmt_interrupt; // interrupt out
   logic                      pm_alarm_flag_clear;  // block b clear pulse
   int                        fails;                // mismatch count
   int                        checks_done;          // comparison count
   int                        clr_cnt = 0;          // clear pulses seen
   logic [31:0]               rd;                   // last read data
   logic                      err;                  // last error response

   wake_event_status_enable dut (.mclk(mclk), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .wake_src(wake_src),
      .kbc_active(kbc_active), .gpio_event_port(gpio_event_port),
      .flag_enable(flag_enable), .power_mgmt_interrupt(power_mgmt_interrupt),
      .pm_alarm_flag_clear(pm_alarm_flag_clear));

   // free running clock, 8 ns period
   always #4 mclk = ~mclk;

   // count clear pulses so a missing or doubled pulse shows up
   always @(posedge mclk) begin
      if (pm_alarm_flag_clear === 1'b1) begin
         clr_cnt <= clr_cnt + 1;
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // one apb transfer; entered just after an edge, leaves one idle cycle
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      // no wait count is assumed: only the watchdog ends a stuck transfer
      while (pready !== 1'b1) begin
         @(posedge mclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   // pulse event sources long enough to pass the input synchronisers
   task automatic pulse(input logic [3:0] s);
      wake_src <= wake_event_pkg::wake_src_s'(s);
      cyc(4);
      wake_src <= wake_event_pkg::wake_src_s'(4'h0);
      cyc(6);
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // watchdog far beyond the few hundred cycles the tests need
   initial begin
      cyc(20000);
      fails++;
      finish_test;
   end

   // main sequence
   initial begin
      mclk = 0; arst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
      pwdata = '0; kbc_active = 0; gpio_event_port = '0; flag_enable = '0;
      fails = 0; checks_done = 0;
      wake_src = wake_event_pkg::wake_src_s'(4'h0);
      cyc(20);
      arst_n <= 1'b1;
      cyc(1);
      apb(0, wake_event_pkg::ADDR_ENABLE, 0); chk(rd, 32'h0, "enable reset");
      apb(0, wake_event_pkg::ADDR_STATUS, 0); chk(rd, 32'h0, "status reset");
      chk(power_mgmt_interrupt, 1'b0, "irq reset");
      apb(1, wake_event_pkg::ADDR_ENABLE, 32'hFFFF_FFA5);
      apb(0, wake_event_pkg::ADDR_ENABLE, 0); chk(rd, 32'hA5, "enable rw");
      apb(0, 12'h0F0, 0); chk(err, 1'b1, "unmapped error");
      chk(rd, 32'h0, "unmapped reads zero");
      apb(1, 12'h0F0, 32'hFF);
      apb(0, wake_event_pkg::ADDR_ENABLE, 0);
      chk(rd, 32'hA5, "unmapped write ignored");
      $display("test registers done");
      // each enable bit gates only its own pin
      for (int p = 0; p < 8; p++) begin
         apb(1, wake_event_pkg::ADDR_ENABLE, 32'h1 << p);
         gpio_event_port <= 8'h1 << ((p + 1) % 8);
         cyc(6); chk(power_mgmt_interrupt, 1'b0, "other pin gated");
         gpio_event_port <= 8'h1 << p;
         cyc(6); chk(power_mgmt_interrupt, 1'b1, "pin enabled");
         gpio_event_port <= 8'h0;
         cyc(6); chk(power_mgmt_interrupt, 1'b0, "pin low");
      end
      apb(1, wake_event_pkg::ADDR_ENABLE, 0);
      $display("test gpio gating done");
      // alarm flag is sticky, zero write ignored, one write clears with pulse
      pulse(4'h1);
      apb(0, wake_event_pkg::ADDR_STATUS, 0); chk(rd, 32'h1, "alarm sticky");
      apb(1, wake_event_pkg::ADDR_STATUS, 0); cyc(2);
      chk(clr_cnt, 0, "no pulse on zero");
      apb(0, wake_event_pkg::ADDR_STATUS, 0); chk(rd, 32'h1, "zero write kept");
      apb(1, wake_event_pkg::ADDR_STATUS, 1); cyc(2); chk(clr_cnt, 1, "clear pulse");
      apb(0, wake_event_pkg::ADDR_STATUS, 0); chk(rd, 32'h0, "alarm cleared");
      $display("test alarm done");
      // controller events refused without wake enable or activity
      kbc_active <= 1'b1;
      pulse(4'hC);
      kbc_active <= 1'b0;
      apb(1, wake_event_pkg::ADDR_WAKECFG, 3);
      pulse(4'hE);
      apb(0, wake_event_pkg::ADDR_STATUS, 0); chk(rd, 32'h0, "refused events");
      // each wake enable bit opens only its own controller section
      kbc_active <= 1'b1;
      apb(1, wake_event_pkg::ADDR_WAKECFG, 32'h1);
      pulse(4'hC);
      apb(0, wake_event_pkg::ADDR_STATUS, 0); chk(rd, 32'h8, "mouse wake only");
      apb(1, wake_event_pkg::ADDR_STATUS, 32'h8);
      apb(1, wake_event_pkg::ADDR_WAKECFG, 32'h2);
      apb(0, wake_event_pkg::ADDR_WAKECFG, 0); chk(rd, 32'h2, "wake config readback");
      pulse(4'hC);
      apb(0, wake_event_pkg::ADDR_STATUS, 0); chk(rd, 32'h4, "keyboard wake only");
      apb(1, wake_event_pkg::ADDR_STATUS, 32'h4);
      apb(1, wake_event_pkg::ADDR_WAKECFG, 32'h3);
      pulse(4'hE);
      apb(0, wake_event_pkg::ADDR_STATUS, 0); chk(rd, 32'hE, "controller events");
      chk(power_mgmt_interrupt, 1'b0, "flags not enabled");
      flag_enable <= 4'h8;
      cyc(3); chk(power_mgmt_interrupt, 1'b1, "mouse flag irq");
      apb(1, wake_event_pkg::ADDR_STATUS, 32'h8);
      apb(0, wake_event_pkg::ADDR_STATUS, 0); chk(rd, 32'h6, "mouse w1c only");
      chk(power_mgmt_interrupt, 1'b0, "irq drops");
      apb(1, wake_event_pkg::ADDR_STATUS, 32'h6);
      apb(0, wake_event_pkg::ADDR_STATUS, 0); chk(rd, 32'h0, "all cleared");
      chk(clr_cnt, 1, "no alarm pulse");
      $display("test controller events done");
      // a second reset in mid-run returns registers and flags to zero
      apb(1, wake_event_pkg::ADDR_ENABLE, 32'h5A);
      pulse(4'h1);
      arst_n <= 1'b0;
      cyc(2);
      chk(power_mgmt_interrupt, 1'b0, "irq in reset");
      arst_n <= 1'b1;
      cyc(1);
      apb(0, wake_event_pkg::ADDR_ENABLE, 0); chk(rd, 32'h0, "enable after reset");
      apb(0, wake_event_pkg::ADDR_STATUS, 0); chk(rd, 32'h0, "status after reset");
      $display("test mid reset done");
      finish_test;
   end
endmodule
